// ### shared/parity_pkg.sv
// constants, types and helper function shared by the byte parity checker
package parity_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int WORD_W = 15;
  localparam int LANES = 2;
  localparam int BYTE_W = 8;
  localparam int DATA_W = LANES * BYTE_W;
  localparam logic [ADDR_W-1:0] CMD_ADDR_HIGH = 16'h0400;
  localparam logic [ADDR_W-1:0] CMD_ADDR_LOW = 16'h0000;

  // ----------------------------------------------------------------
  // apb map and fields
  // ----------------------------------------------------------------
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] CMD_OFF = 8'h00;
  localparam logic [PADDR_W-1:0] STAT_OFF = 8'h04;
  localparam logic [PADDR_W-1:0] CFG_OFF = 8'h08;
  localparam int CMD_W = 4;
  localparam int CMD_IRQ_EN = 0;
  localparam int CMD_NMI_EN = 1;
  localparam int CMD_IND_EN = 2;
  localparam int CMD_EVEN = 3;
  localparam logic [CMD_W-1:0] CMD_RESET = 4'h0;
  localparam int CFG_W = 3;
  localparam int CFG_CMD_AT_ZERO = 0;
  localparam int CFG_PF_EN = 1;
  localparam int CFG_GATE_INV = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
  localparam int ST_W = 6;
  localparam int ST_IRQ = 2;
  localparam int ST_NMI = 3;
  localparam int ST_PF = 4;
  localparam int ST_READY = 5;

  // ----------------------------------------------------------------
  // pins and timing
  // ----------------------------------------------------------------
  localparam int CTL_W = 5;
  localparam logic [CTL_W-1:0] CTL_IDLE = 5'h07;
  localparam int CLK_MHZ = 200;
  localparam int POWER_UP_MS = 10;
  localparam int POWER_UP_CYCLES = POWER_UP_MS * CLK_MHZ * 1000;
  localparam int GATE_PULSE_NS = 30;
  localparam int GATE_PULSE_CYCLES = (GATE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_IRQ_NS = 70;
  localparam int CLEAR_IRQ_CYCLES = CLEAR_IRQ_NS * CLK_MHZ / 1000;
  localparam int GATE_CLEAR_NS = 104;
  localparam int GATE_CLEAR_CYCLES = GATE_CLEAR_NS * CLK_MHZ / 1000;
  localparam int READ_OUT_NS = 72;
  localparam int READ_OUT_CYCLES = READ_OUT_NS * CLK_MHZ / 1000;

  // read sequence states
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_ACTIVE = 3'b010,
    RD_CHECKED = 3'b100
  } rd_state_t;

  // parity bit of one byte; odd mode makes the nine bits odd
  function automatic logic parity_bit(input logic [BYTE_W-1:0] b, input logic odd);
    return (^b) ^ odd;
  endfunction

endpackage

// ### shared/parity_mem_if.sv
// carrier between the checker and its parity bit memory
`timescale 1ns/1ps
interface parity_mem_if #(parameter int WORD_W = 15, parameter int LANES = 2);
  logic wr_en;
  logic [LANES-1:0] wr_lane;
  logic [WORD_W-1:0] wr_addr;
  logic [LANES-1:0] wr_bits;
  logic rd_en;
  logic [WORD_W-1:0] rd_addr;
  logic [LANES-1:0] rd_bits;
  modport ctrl (output wr_en, output wr_lane, output wr_addr, output wr_bits,
                output rd_en, output rd_addr, input rd_bits);
  modport mem (input wr_en, input wr_lane, input wr_addr, input wr_bits,
               input rd_en, input rd_addr, output rd_bits);
endinterface

// ### hdl/parity_bit_mem.sv
// parity bit store, one bit per byte lane per word, registered read
`timescale 1ns/1ps
module parity_bit_mem #(
  parameter int WORD_W = 15,
  parameter int LANES = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // access port
  parity_mem_if.mem port
);
  // one bit array per lane: a byte write leaves the other lane alone,
  // and each array has exactly one writing process
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : lane
      logic lane_bits [0:(2**WORD_W)-1];

      // write port of this lane
      always_ff @(posedge pclk) begin
        if (port.wr_en && port.wr_lane[g]) begin
          lane_bits[port.wr_addr] <= port.wr_bits[g];
        end
      end

      // read data comes out of a register, valid the cycle after rd_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port.rd_bits[g] <= 1'b0;
        end else if (port.rd_en) begin
          port.rd_bits[g] <= lane_bits[port.rd_addr];
        end
      end
    end
  endgenerate
endmodule

// ### hdl/byte_parity_checker.sv
// byte lane parity generator and checker beside host dynamic ram
`timescale 1ns/1ps
module byte_parity_checker
  import parity_pkg::*;
#(
  parameter int POWER_UP_COUNT = parity_pkg::POWER_UP_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [parity_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host memory cycle pins
  input wire logic [parity_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [parity_pkg::DATA_W-1:0] mem_data,
  input wire logic [parity_pkg::LANES-1:0] lane_enable,
  input wire logic lane_write_strobe_n,
  input wire logic dual_port_read_strobe_n,
  input wire logic column_strobe_n,
  // interrupt control pins
  input wire logic nonmaskable_gate,
  input wire logic power_fail_input,
  // error outputs
  output logic maskable_error_irq,
  output logic nonmaskable_irq,
  output logic byte0_check_status,
  output logic byte1_check_status,
  output logic [parity_pkg::LANES-1:0] lane_indicator,
  output logic access_ready
);
  import parity_pkg::*;

  // bounds for the checks below
  localparam int CLR_MAX = CLEAR_IRQ_CYCLES;
  localparam int GATE_MAX = GATE_CLEAR_CYCLES;
  localparam int OUT_MAX = READ_OUT_CYCLES;
  localparam int BUS_W = ADDR_W + DATA_W + LANES;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctl_a;
  logic [CTL_W-1:0] ctl_b;
  logic [CTL_W-1:0] ctl_prev;
  logic [BUS_W-1:0] bus_a;
  logic [BUS_W-1:0] bus_b;

  // strobes reset to their idle level so release makes no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_a <= CTL_IDLE;
      ctl_b <= CTL_IDLE;
      ctl_prev <= CTL_IDLE;
    end else begin
      ctl_a <= {power_fail_input, nonmaskable_gate, column_strobe_n,
                dual_port_read_strobe_n, lane_write_strobe_n};
      ctl_b <= ctl_a;
      ctl_prev <= ctl_b;
    end
  end

  // address and data settle well before the strobe edges they go with
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_a <= '0;
      bus_b <= '0;
    end else begin
      bus_a <= {lane_enable, mem_data, mem_addr};
      bus_b <= bus_a;
    end
  end

  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [LANES-1:0] lane_s;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic cas_rise;
  logic gate_s;
  logic pf_s;

  // edge detection on second stage only
  assign addr_s = bus_b[ADDR_W-1:0];
  assign data_s = bus_b[ADDR_W +: DATA_W];
  assign lane_s = bus_b[ADDR_W+DATA_W +: LANES];
  assign wr_rise = ctl_b[0] && !ctl_prev[0];
  assign rd_fall = !ctl_b[1] && ctl_prev[1];
  assign rd_rise = ctl_b[1] && !ctl_prev[1];
  assign cas_rise = ctl_b[2] && !ctl_prev[2];
  assign gate_s = ctl_b[3];
  assign pf_s = ctl_b[4];

  // ----------------------------------------------------------------
  // power up hold off
  // ----------------------------------------------------------------
  logic [31:0] up_count;

  // strobes before the host's settle time are not trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_count <= '0;
      access_ready <= 1'b0;
    end else if (!access_ready) begin
      up_count <= up_count + 32'h0000_0001;
      access_ready <= (up_count + 32'h0000_0001) >= 32'(POWER_UP_COUNT);
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic [CMD_W-1:0] cmd;
  logic [CFG_W-1:0] cfg;
  logic [ST_W-1:0] status_word;
  logic apb_wr;
  logic apb_hit;
  logic cmd_clear;
  logic cmd_hit;
  logic odd_mode;
  logic gate_eff;
  logic gate_prev;
  logic gate_rise;
  logic pf_term;

  function automatic logic mapped(input logic [PADDR_W-1:0] a);
    return (a == CMD_OFF) || (a == STAT_OFF) || (a == CFG_OFF);
  endfunction

  // zero wait states: answer in the first access cycle
  assign pready = 1'b1;
  assign apb_hit = mapped(paddr);
  assign pslverr = psel && penable && !apb_hit;
  assign apb_wr = psel && penable && pwrite;

  // command latch cleared at reset: odd parity, all masked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= CMD_RESET;
    end else if (cmd_clear) begin
      cmd <= data_s[CMD_W-1:0];
    end else if (apb_wr && paddr == CMD_OFF) begin
      cmd <= pwdata[CMD_W-1:0];
    end
  end

  // configuration options, power fail ignored by default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (apb_wr && paddr == CFG_OFF) begin
      cfg <= pwdata[CFG_W-1:0];
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        CMD_OFF: prdata <= {{(32-CMD_W){1'b0}}, cmd};
        STAT_OFF: prdata <= {{(32-ST_W){1'b0}}, status_word};
        CFG_OFF: prdata <= {{(32-CFG_W){1'b0}}, cfg};
        default: prdata <= '0;
      endcase
    end
  end

  assign status_word = {access_ready, pf_s, nonmaskable_irq, maskable_error_irq,
                        byte1_check_status, byte0_check_status};

  // ----------------------------------------------------------------
  // command port decode
  // ----------------------------------------------------------------
  // port address picked by option, high address by default
  assign cmd_hit = lane_s[0] && (addr_s == (cfg[CFG_CMD_AT_ZERO] ? CMD_ADDR_LOW
                                                                  : CMD_ADDR_HIGH));
  assign cmd_clear = wr_rise && access_ready && cmd_hit;
  assign odd_mode = !cmd[CMD_EVEN];

  // gate polarity option, then rising edge of the effective level
  assign gate_eff = gate_s ^ cfg[CFG_GATE_INV];
  assign gate_rise = gate_eff && !gate_prev;
  assign pf_term = cfg[CFG_PF_EN] && pf_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_prev <= 1'b0;
    end else begin
      gate_prev <= gate_eff;
    end
  end

  // ----------------------------------------------------------------
  // parity memory
  // ----------------------------------------------------------------
  parity_mem_if #(.WORD_W(WORD_W), .LANES(LANES)) pm ();

  parity_bit_mem #(.WORD_W(WORD_W), .LANES(LANES)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .port(pm.mem)
  );

  rd_state_t rd_state;
  rd_state_t next_rd_state;
  logic [LANES-1:0] gen_bits;
  logic [LANES-1:0] check_bits;
  logic [LANES-1:0] pend;

  // per byte generation and check share one function
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : lane_par
      assign gen_bits[g] = parity_bit(data_s[g*BYTE_W +: BYTE_W], odd_mode);
      assign check_bits[g] = gen_bits[g] ^ pm.rd_bits[g];
    end
  endgenerate

  // bit stored as the write strobe ends; no stall toward host
  assign pm.wr_en = wr_rise && access_ready && rd_state == RD_IDLE;
  assign pm.wr_lane = lane_s;
  assign pm.wr_addr = addr_s[ADDR_W-1:1]; // 64K bytes as 32K word pairs
  assign pm.wr_bits = gen_bits;
  assign pm.rd_en = rd_fall && access_ready;
  assign pm.rd_addr = addr_s[ADDR_W-1:1];

  // ----------------------------------------------------------------
  // read check sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      RD_IDLE: begin
        if (pm.rd_en) begin
          next_rd_state = RD_ACTIVE;
        end
      end
      RD_ACTIVE: begin
        if (rd_rise) begin
          next_rd_state = RD_IDLE;
        end else if (cas_rise) begin
          next_rd_state = RD_CHECKED;
        end
      end
      RD_CHECKED: begin
        if (rd_rise) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state <= RD_IDLE;
    end else begin
      rd_state <= next_rd_state;
    end
  end

  // check latched at column strobe rise, high is error
  // a lane only reports when its own byte was read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
    end else if (pm.rd_en) begin
      pend <= '0;
    end else if (rd_state == RD_ACTIVE && cas_rise && !rd_rise) begin
      pend <= check_bits & lane_s;
    end
  end

  logic err_event;
  logic [LANES-1:0] lane_status;

  // results surface as the read strobe ends
  assign err_event = rd_rise && rd_state == RD_CHECKED && (|pend);

  // ----------------------------------------------------------------
  // error latches and outputs
  // ----------------------------------------------------------------
  // per lane status, a new error wins over a same cycle clear
  generate
    for (g = 0; g < LANES; g++) begin : lane_st
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lane_status[g] <= 1'b0;
        end else if (rd_rise && rd_state == RD_CHECKED && pend[g]) begin
          lane_status[g] <= 1'b1;
        end else if (cmd_clear) begin
          lane_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign byte0_check_status = lane_status[0];
  assign byte1_check_status = lane_status[1];

  // indicators follow status once software enables them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_indicator <= '0;
    end else begin
      lane_indicator <= lane_status & {LANES{cmd[CMD_IND_EN]}};
    end
  end

  // sticky maskable latch; sets only while the command enables the maskable irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maskable_error_irq <= 1'b0;
    end else if (err_event && cmd[CMD_IRQ_EN]) begin
      maskable_error_irq <= 1'b1;
    end else if (cmd_clear) begin
      maskable_error_irq <= 1'b0;
    end
  end

  logic nmi_latch;

  // gated nonmaskable latch, cleared by command or gate rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_latch <= 1'b0;
    end else if (err_event && cmd[CMD_NMI_EN] && !gate_eff) begin
      nmi_latch <= 1'b1;
    end else if (cmd_clear || gate_rise) begin
      nmi_latch <= 1'b0;
    end
  end

  // power fail joins the output only while the gate is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonmaskable_irq <= 1'b0;
    end else begin
      nonmaskable_irq <= (nmi_latch || pf_term) && !gate_eff;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cmd_clears_irq: assert property (
    cmd_clear && !rd_rise |-> ##[1:CLR_MAX] !maskable_error_irq && !byte0_check_status)
    else $error("command write did not clear maskable irq and status");

  chk_cmd_clears_nmi: assert property (
    cmd_clear && !rd_rise && !pf_term |=> !nmi_latch ##1 !nonmaskable_irq)
    else $error("command write did not clear nonmaskable irq");

  chk_gate_clears_nmi: assert property (
    gate_rise && !pf_term |-> ##[1:GATE_MAX] !nonmaskable_irq)
    else $error("gate rise did not clear nonmaskable irq");

  chk_error_sets_irq: assert property (
    err_event && cmd[CMD_IRQ_EN] |-> ##[1:OUT_MAX] maskable_error_irq)
    else $error("parity error did not raise maskable irq");

  chk_irq_sticky: assert property (
    maskable_error_irq && !cmd_clear |=> maskable_error_irq)
    else $error("maskable irq dropped without a command write");

  chk_pf_ignored: assert property (
    !cfg[CFG_PF_EN] && !nmi_latch |=> !nonmaskable_irq)
    else $error("power fail reached nmi while disabled");

  chk_pf_drives_nmi: assert property (
    pf_term && !gate_eff |=> nonmaskable_irq)
    else $error("enabled power fail did not raise nmi");

  chk_status_at_read: assert property (
    $rose(byte1_check_status) |-> $past(rd_rise) && $past(pend[1]))
    else $error("upper status rose outside a checked read end");

  chk_no_write_early: assert property (
    !access_ready |-> !pm.wr_en && !pm.rd_en)
    else $error("memory touched before power up delay");

endmodule

// ### dv/host_mem_model.sv
// host side model: memory cycle strobes, address, data and control pins
`timescale 1ns/1ps
module host_mem_model
  import parity_pkg::*;
(
  // clock and status
  input wire logic pclk,
  input wire logic access_ready,
  // host memory pins
  output logic [parity_pkg::ADDR_W-1:0] mem_addr,
  output logic [parity_pkg::DATA_W-1:0] mem_data,
  output logic [parity_pkg::LANES-1:0] lane_enable,
  output logic lane_write_strobe_n,
  output logic dual_port_read_strobe_n,
  output logic column_strobe_n,
  // control pins
  output logic nonmaskable_gate,
  output logic power_fail_input
);
  // idle pins at time zero, strobes high
  initial begin
    mem_addr = 16'h0000;
    mem_data = 16'h0000;
    lane_enable = 2'h0;
    lane_write_strobe_n = 1'b1;
    dual_port_read_strobe_n = 1'b1;
    column_strobe_n = 1'b1;
    nonmaskable_gate = 1'b0;
    power_fail_input = 1'b0;
  end

  // no access before the power-up wait has run out
  task automatic wait_ready(output bit ok);
    int i;
    ok = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (access_ready === 1'b1) begin
        ok = 1;
        break;
      end
    end
  endtask

  // one memory cycle; pins settle 4 clocks around every strobe edge
  task automatic cyc(input bit wr, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] le);
    @(posedge pclk);
    mem_addr <= a;
    mem_data <= d;
    lane_enable <= le;
    repeat (4) @(posedge pclk);
    if (wr) lane_write_strobe_n <= 1'b0;
    else dual_port_read_strobe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    if (!wr) column_strobe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    column_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
    lane_write_strobe_n <= 1'b1;
    dual_port_read_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
    // released bus shows the inverse, never the stale value
    mem_addr <= ~a;
    mem_data <= ~d;
    lane_enable <= 2'h0;
    repeat (8) @(posedge pclk);
  endtask

  // gate and power fail levels, held well past the minimum pulse
  task automatic ctl(input logic g, input logic pf);
    @(posedge pclk);
    nonmaskable_gate <= g;
    power_fail_input <= pf;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// ### dv/byte_parity_checker_tb.sv
// self-checking bench for the byte parity checker
`timescale 1ns/1ps
module byte_parity_checker_tb;
  import parity_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic [15:0] mem_addr, mem_data;
  logic [1:0] lane_enable, lane_indicator;
  logic wsn, rsn, csn, gate, pf, irq, nmi, st0, st1, ready;
  int n_fail = 0, num_checks = 0;
  bit ok;

  always #2.5 pclk = ~pclk;

  byte_parity_checker #(.POWER_UP_COUNT(16)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_data(mem_data), .lane_enable(lane_enable), .lane_write_strobe_n(wsn),
    .dual_port_read_strobe_n(rsn), .column_strobe_n(csn), .nonmaskable_gate(gate),
    .power_fail_input(pf), .maskable_error_irq(irq), .nonmaskable_irq(nmi),
    .byte0_check_status(st0), .byte1_check_status(st1),
    .lane_indicator(lane_indicator), .access_ready(ready));

  host_mem_model host (.pclk(pclk), .access_ready(ready), .mem_addr(mem_addr),
    .mem_data(mem_data), .lane_enable(lane_enable), .lane_write_strobe_n(wsn),
    .dual_port_read_strobe_n(rsn), .column_strobe_n(csn), .nonmaskable_gate(gate),
    .power_fail_input(pf));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  // irq, nmi, upper status, lower status, indicators
  task automatic outs(input logic [5:0] e);
    chk("outs", {26'h0, irq, nmi, st1, st0, lane_indicator}, {26'h0, e});
  endtask

  // apb transfer; waits on pready under a bound, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      end_sim();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CMD_OFF, 32'h0);
    chk("cmd reset", rdat, 32'h0);
    apb(1'b0, CFG_OFF, 32'h0);
    chk("cfg reset", rdat, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    host.wait_ready(ok);
    chk("ready", {31'h0, ok}, 32'h1);
    if (!ok) end_sim();
    $display("test reset done");
    // lower lane error in odd mode, all enables on
    apb(1'b1, CMD_OFF, 32'h7);
    host.cyc(1'b1, 16'h0010, 16'h1234, 2'h3);
    host.cyc(1'b0, 16'h0010, 16'h1234, 2'h3);
    outs(6'b000000);
    host.cyc(1'b0, 16'h0010, 16'h1235, 2'h3);
    outs(6'b110101);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("stat", rdat, 32'h2d);
    // command write at the default port clears everything
    host.cyc(1'b1, CMD_ADDR_HIGH, 16'h0007, 2'h1);
    outs(6'b000000);
    $display("test lower lane done");
    // upper lane error, then gate clears only the nmi
    host.cyc(1'b0, 16'h0010, 16'h0234, 2'h3);
    outs(6'b111010);
    host.ctl(1'b1, 1'b0);
    outs(6'b101010);
    host.ctl(1'b0, 1'b0);
    outs(6'b101010);
    $display("test gate done");
    // power fail ignored by default, then enabled, then gate inverted
    host.ctl(1'b0, 1'b1);
    chk("nmi pf off", {31'h0, nmi}, 32'h0);
    apb(1'b1, CFG_OFF, 32'h2);
    repeat (8) @(posedge pclk);
    chk("nmi pf on", {31'h0, nmi}, 32'h1);
    apb(1'b1, CFG_OFF, 32'h6);
    repeat (8) @(posedge pclk);
    chk("nmi inv gate", {31'h0, nmi}, 32'h0);
    host.ctl(1'b1, 1'b1);
    chk("nmi inv open", {31'h0, nmi}, 32'h1);
    host.ctl(1'b0, 1'b0);
    $display("test power fail done");
    // port moved to 0H; new command selects even parity
    apb(1'b1, CFG_OFF, 32'h1);
    host.cyc(1'b1, CMD_ADDR_LOW, 16'h000f, 2'h1);
    outs(6'b000000);
    apb(1'b0, CMD_OFF, 32'h0);
    chk("cmd via port", rdat, 32'hf);
    host.cyc(1'b0, 16'h0010, 16'h1234, 2'h3);
    outs(6'b111111);
    $display("test even mode done");
    end_sim();
  end
endmodule
